// ---- verilog/gpio_port_pkg.sv ----
package gpio_port_pkg;

    localparam int REG_W = 8;
    localparam int PA_W = 8;
    localparam int PB_W = 5;
    localparam int ADDR_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam int STRENGTH_BIT = 0;

    // data-memory addresses of the port registers
    localparam logic [ADDR_W-1:0] ADDR_PORT_A_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PORT_A_DIR = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_PORT_A_PU = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_PORT_A_WAKE = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_PORT_B_DATA = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_PORT_B_DIR = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_PORT_B_PU = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_PU_STRENGTH = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_DRIVE_LEVEL = 8'h08;

    localparam logic [PA_W-1:0] RST_PA_DATA = 8'hff;
    localparam logic [PA_W-1:0] RST_PA_DIR = 8'hff;
    localparam logic [PA_W-1:0] RST_PA_PU = 8'h00;
    localparam logic [PA_W-1:0] RST_PA_WAKE = 8'h00;
    localparam logic [PB_W-1:0] RST_PB_DATA = 5'h1f;
    localparam logic [PB_W-1:0] RST_PB_DIR = 5'h1f;
    localparam logic [PB_W-1:0] RST_PB_PU = 5'h00;
    localparam logic RST_STRENGTH = 1'b0;
    localparam logic [REG_W-1:0] RST_DRIVE_LEVEL = 8'h00;
    localparam logic [REG_W-1:0] READ_NONE = 8'h00;

    typedef struct packed {
        logic [PA_W-1:0] a_data_q;
        logic [PA_W-1:0] a_dir_q;
        logic [PA_W-1:0] a_pu_q;
        logic [PA_W-1:0] a_wake_q;
        logic [PB_W-1:0] b_data_q;
        logic [PB_W-1:0] b_dir_q;
        logic [PB_W-1:0] b_pu_q;
        logic strength_q;
        logic [REG_W-1:0] drive_q;
        logic [PA_W-1:0] a_prev_q;
        logic [REG_W-1:0] rdata_q;
        logic [PA_W-1:0] a_oe_q;
        logic [PA_W-1:0] a_pull_q;
        logic [PA_W-1:0] a_strong_q;
        logic [PB_W-1:0] b_oe_q;
        logic [PB_W-1:0] b_pull_q;
        logic [PB_W-1:0] b_strong_q;
        logic wake_q;
    } port_state_t;

    localparam port_state_t STATE_RST = '{
        a_data_q: RST_PA_DATA,
        a_dir_q: RST_PA_DIR,
        a_pu_q: RST_PA_PU,
        a_wake_q: RST_PA_WAKE,
        b_data_q: RST_PB_DATA,
        b_dir_q: RST_PB_DIR,
        b_pu_q: RST_PB_PU,
        strength_q: RST_STRENGTH,
        drive_q: RST_DRIVE_LEVEL,
        a_prev_q: 8'hff,
        rdata_q: READ_NONE,
        a_oe_q: 8'h00,
        a_pull_q: 8'h00,
        a_strong_q: 8'h00,
        b_oe_q: 5'h00,
        b_pull_q: 5'h00,
        b_strong_q: 5'h00,
        wake_q: 1'b0
    };

endpackage

// ---- verilog/pin_sync.sv ----
module pin_sync
    import gpio_port_pkg::*;
#(
    parameter int W = PA_W,
    parameter logic [W-1:0] INIT = '1
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync_q
);

    typedef struct packed {
        logic [W-1:0] meta_q;
        logic [W-1:0] sync_q;
    } sync_state_t;

    sync_state_t q;
    sync_state_t d;

    // first stage feeds only the second stage
    always_comb
    begin
        d.meta_q = pin_in;
        d.sync_q = q.meta_q;
    end

    // reset to the idle level so no false edge follows reset
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            q <= '{meta_q: INIT, sync_q: INIT};
        else
            q <= d;
    end

    assign pin_sync_q = q.sync_q;

endmodule

// ---- verilog/general_io_port_logic.sv ----
module general_io_port_logic
    import gpio_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [REG_W-1:0] mem_wdata,
    output logic [REG_W-1:0] mem_rdata,
    input wire logic cpu_idle,
    input wire logic wdt_rst,
    input wire logic [PA_W-1:0] func_gpio_a,
    input wire logic [PB_W-1:0] func_gpio_b,
    input wire logic [PA_W-1:0] pa_in,
    output logic [PA_W-1:0] pa_out,
    output logic [PA_W-1:0] pa_oe,
    output logic [PA_W-1:0] pa_pull_en,
    output logic [PA_W-1:0] pa_pull_strong,
    input wire logic [PB_W-1:0] pb_in,
    output logic [PB_W-1:0] pb_out,
    output logic [PB_W-1:0] pb_oe,
    output logic [PB_W-1:0] pb_pull_en,
    output logic [PB_W-1:0] pb_pull_strong,
    output logic [REG_W-1:0] drive_level,
    output logic wake_req
);

    port_state_t q;
    port_state_t n;
    logic [PA_W-1:0] a_sync;
    logic [PB_W-1:0] b_sync;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    pin_sync #(.W(PA_W), .INIT(RST_PA_DATA)) u_sync_a (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin_in(pa_in),
        .pin_sync_q(a_sync)
    );

    pin_sync #(.W(PB_W), .INIT(RST_PB_DATA)) u_sync_b (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pin_in(pb_in),
        .pin_sync_q(b_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        logic [PA_W-1:0] a_fall;
        logic [PA_W-1:0] a_armed;
        logic [PA_W-1:0] a_read;
        logic [PB_W-1:0] b_read;
        a_fall = q.a_prev_q & ~a_sync;
        a_armed = q.a_wake_q & q.a_dir_q & func_gpio_a & {PA_W{cpu_idle}};
        // inputs read the pin, outputs read the latch
        a_read = (q.a_dir_q & a_sync) | (~q.a_dir_q & q.a_data_q);
        b_read = (q.b_dir_q & b_sync) | (~q.b_dir_q & q.b_data_q);
        n = q;

        // watchdog in normal run restores reset values; in idle it leaves them
        if (wdt_rst && !cpu_idle)
        begin
            n.a_data_q = RST_PA_DATA;
            n.a_dir_q = RST_PA_DIR;
            n.a_pu_q = RST_PA_PU;
            n.a_wake_q = RST_PA_WAKE;
            n.b_data_q = RST_PB_DATA;
            n.b_dir_q = RST_PB_DIR;
            n.b_pu_q = RST_PB_PU;
            n.strength_q = RST_STRENGTH;
            n.drive_q = RST_DRIVE_LEVEL;
        end
        else if (mem_wr)
        begin
            if (mem_addr == ADDR_PORT_A_DATA)
                n.a_data_q = mem_wdata;
            else if (mem_addr == ADDR_PORT_A_DIR)
                n.a_dir_q = mem_wdata;
            else if (mem_addr == ADDR_PORT_A_PU)
                n.a_pu_q = mem_wdata;
            else if (mem_addr == ADDR_PORT_A_WAKE)
                n.a_wake_q = mem_wdata;
            else if (mem_addr == ADDR_PORT_B_DATA)
                n.b_data_q = mem_wdata[PB_W-1:0];
            else if (mem_addr == ADDR_PORT_B_DIR)
                n.b_dir_q = mem_wdata[PB_W-1:0];
            else if (mem_addr == ADDR_PORT_B_PU)
                n.b_pu_q = mem_wdata[PB_W-1:0];
            else if (mem_addr == ADDR_PU_STRENGTH)
                n.strength_q = mem_wdata[STRENGTH_BIT];
            else if (mem_addr == ADDR_DRIVE_LEVEL)
                n.drive_q = mem_wdata;
        end

        // read data is held until the next read
        if (mem_rd)
        begin
            if (mem_addr == ADDR_PORT_A_DATA)
                n.rdata_q = a_read;
            else if (mem_addr == ADDR_PORT_A_DIR)
                n.rdata_q = q.a_dir_q;
            else if (mem_addr == ADDR_PORT_A_PU)
                n.rdata_q = q.a_pu_q;
            else if (mem_addr == ADDR_PORT_A_WAKE)
                n.rdata_q = q.a_wake_q;
            else if (mem_addr == ADDR_PORT_B_DATA)
                n.rdata_q = {{(REG_W-PB_W){1'b0}}, b_read};
            else if (mem_addr == ADDR_PORT_B_DIR)
                n.rdata_q = {{(REG_W-PB_W){1'b0}}, q.b_dir_q};
            else if (mem_addr == ADDR_PORT_B_PU)
                n.rdata_q = {{(REG_W-PB_W){1'b0}}, q.b_pu_q};
            else if (mem_addr == ADDR_PU_STRENGTH)
                n.rdata_q = {{(REG_W-1){1'b0}}, q.strength_q};
            else if (mem_addr == ADDR_DRIVE_LEVEL)
                n.rdata_q = q.drive_q;
            else
                n.rdata_q = READ_NONE;
        end

        // one pulse however many pins fall in the same cycle
        n.wake_q = |(a_fall & a_armed);
        n.a_prev_q = a_sync;

        // pin-side outputs follow the new register values
        n.a_oe_q = ~n.a_dir_q;
        n.b_oe_q = ~n.b_dir_q;
        n.a_pull_q = n.a_pu_q & n.a_dir_q & func_gpio_a;
        n.b_pull_q = n.b_pu_q & n.b_dir_q & func_gpio_b;
        n.a_strong_q = n.a_pull_q & {PA_W{n.strength_q}};
        n.b_strong_q = n.b_pull_q & {PB_W{n.strength_q}};
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            q <= STATE_RST;
        else
            q <= n;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign mem_rdata = q.rdata_q;
    assign pa_out = q.a_data_q;
    assign pa_oe = q.a_oe_q;
    assign pa_pull_en = q.a_pull_q;
    assign pa_pull_strong = q.a_strong_q;
    assign pb_out = q.b_data_q;
    assign pb_oe = q.b_oe_q;
    assign pb_pull_en = q.b_pull_q;
    assign pb_pull_strong = q.b_strong_q;
    assign drive_level = q.drive_q;
    assign wake_req = q.wake_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    latch_hold_a: assert property (
        !(mem_wr && mem_addr == ADDR_PORT_A_DATA) && !wdt_rst |=> $stable(pa_out))
        else $error("port a output latch changed without a write");

    dir_oe_a: assert property (
        mem_wr && mem_addr == ADDR_PORT_A_DIR && !wdt_rst
        |=> pa_oe == ~$past(mem_wdata))
        else $error("port a enables do not follow written direction");

    read_latch_a: assert property (
        mem_rd && mem_addr == ADDR_PORT_A_DATA && q.a_dir_q == 8'h00
        |=> mem_rdata == $past(q.a_data_q))
        else $error("output pin read did not return latch");

    read_pin_a: assert property (
        mem_rd && mem_addr == ADDR_PORT_A_DATA && q.a_dir_q == 8'hff
        |=> mem_rdata == $past(a_sync))
        else $error("input pin read did not return pin level");

    pull_gate_a: assert property (
        ##1 pa_pull_en == (q.a_pu_q & q.a_dir_q & $past(func_gpio_a)))
        else $error("pull-high active outside gpio input");

    strength_gate_a: assert property (
        (pa_pull_strong & ~pa_pull_en) == 8'h00 && (pb_pull_strong & ~pb_pull_en) == 5'h00)
        else $error("strong pull on a disabled pull-high");

    strength_read_a: assert property (
        mem_rd && mem_addr == ADDR_PU_STRENGTH |=> mem_rdata[7:1] == 7'h00)
        else $error("strength register upper bits not zero");

    b_upper_zero_a: assert property (
        mem_rd && (mem_addr == ADDR_PORT_B_DATA || mem_addr == ADDR_PORT_B_DIR
        || mem_addr == ADDR_PORT_B_PU) |=> mem_rdata[7:5] == 3'h0)
        else $error("port b unimplemented bits not zero");

    wdt_idle_keep_a: assert property (
        wdt_rst && cpu_idle && !mem_wr |=> $stable(q.a_dir_q) && $stable(q.b_pu_q))
        else $error("watchdog in idle altered port registers");

    wdt_run_reset_a: assert property (
        wdt_rst && !cpu_idle |=> q.a_dir_q == RST_PA_DIR && q.a_wake_q == RST_PA_WAKE)
        else $error("watchdog in run did not restore reset values");

    wake_fire_a: assert property (
        cpu_idle && |(q.a_prev_q & ~a_sync & q.a_wake_q & q.a_dir_q & func_gpio_a)
        |=> wake_req)
        else $error("enabled falling edge did not raise wake");

    wake_cause_a: assert property (
        wake_req |-> $past(cpu_idle) && $past(|(q.a_wake_q & q.a_dir_q)))
        else $error("wake raised without idle or enabled input");

    wake_pulse_a: assert property (
        wake_req |=> !wake_req || $past(|(q.a_prev_q & ~a_sync)))
        else $error("wake held longer than one edge");

    wake_seen_c: cover property (cpu_idle ##1 wake_req);
    input_read_c: cover property (mem_rd && mem_addr == ADDR_PORT_A_DATA ##1 mem_rdata != 8'hff);
    wdt_idle_c: cover property (wdt_rst && cpu_idle);
    strong_pull_c: cover property (pa_pull_strong != 8'h00);

endmodule

// ---- sim/pin_side_model.sv ----
module pin_side_model
    import gpio_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [PA_W-1:0] pa_out,
    input wire logic [PA_W-1:0] pa_oe,
    input wire logic [PA_W-1:0] pa_pull_en,
    input wire logic [PB_W-1:0] pb_out,
    input wire logic [PB_W-1:0] pb_oe,
    input wire logic [PB_W-1:0] pb_pull_en,
    input wire logic [PA_W-1:0] sw_a,
    input wire logic [PA_W-1:0] short_a,
    output logic [PA_W-1:0] pa_in,
    output logic [PB_W-1:0] pb_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // undriven, unpulled lines toggle so a stale level is never trusted
    logic flt_q = 1'b0;

    always @(posedge ref_clk)
    begin
        flt_q <= ~flt_q;
    end

    always_comb
    begin
        for (int i = 0; i < PA_W; i++)
        begin
            pa_in[i] = short_a[i] ? 1'b0 : pa_oe[i] ? pa_out[i] : sw_a[i] ? 1'b0 :
                pa_pull_en[i] ? 1'b1 : flt_q;
        end
        for (int i = 0; i < PB_W; i++)
        begin
            // b0/b1 face the bridge and its pull-low
            pb_in[i] = pb_oe[i] ? pb_out[i] : pb_pull_en[i] ? 1'b1 : (i < 2) ? 1'b0 : flt_q;
        end
    end
endmodule

// ---- sim/general_io_port_logic_tb.sv ----
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

module general_io_port_logic_tb;
    import gpio_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk = 1'b0;
    logic nrst, mem_wr, mem_rd, cpu_idle, wdt_rst, wake_req;
    logic [7:0] mem_addr, mem_wdata, mem_rdata, drive_level;
    logic [7:0] func_gpio_a, pa_in, pa_out, pa_oe, pa_pull_en, pa_pull_strong, sw_a, short_a;
    logic [4:0] func_gpio_b, pb_in, pb_out, pb_oe, pb_pull_en, pb_pull_strong;
    int fails = 0;
    int n_compared = 0;

    always #4 ref_clk = ~ref_clk;

    general_io_port_logic dut_u (.ref_clk(ref_clk), .nrst(nrst), .mem_wr(mem_wr),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .cpu_idle(cpu_idle), .wdt_rst(wdt_rst), .func_gpio_a(func_gpio_a),
        .func_gpio_b(func_gpio_b), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
        .pa_pull_en(pa_pull_en), .pa_pull_strong(pa_pull_strong), .pb_in(pb_in),
        .pb_out(pb_out), .pb_oe(pb_oe), .pb_pull_en(pb_pull_en),
        .pb_pull_strong(pb_pull_strong), .drive_level(drive_level), .wake_req(wake_req));

    pin_side_model pins_u (.ref_clk(ref_clk), .pa_out(pa_out), .pa_oe(pa_oe),
        .pa_pull_en(pa_pull_en), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pull_en(pb_pull_en),
        .sw_a(sw_a), .short_a(short_a), .pa_in(pa_in), .pb_in(pb_in));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        mem_wr <= 1'b1;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge ref_clk);
        mem_wr <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        mem_rd <= 1'b1;
        mem_addr <= a;
        @(posedge ref_clk);
        mem_rd <= 1'b0;
        @(negedge ref_clk);
        d = mem_rdata;
    endtask

    task automatic count_wake(output int n);
        n = 0;
        repeat (12) @(negedge ref_clk) if (wake_req === 1'b1) n++;
    endtask

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] v;
        logic [7:0] adr [8] = '{ADDR_PORT_A_DIR, ADDR_PORT_A_PU, ADDR_PORT_A_WAKE,
            ADDR_PORT_B_DIR, ADDR_PORT_B_PU, ADDR_PU_STRENGTH, ADDR_DRIVE_LEVEL, 8'h09};
        logic [7:0] exp [8] = '{8'hff, 8'h00, 8'h00, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
        `CHK("pa_out", 8'hff, pa_out)
        `CHK("pa_oe", 8'h00, pa_oe)
        for (int i = 0; i < 8; i++)
        begin
            rd(adr[i], v);
            `CHK("reset read", exp[i], v)
        end
        $display("done reset");
    endtask

    task automatic t_output;
        logic [7:0] v;
        wr(ADDR_PORT_A_PU, 8'hff);
        wr(ADDR_PORT_A_DIR, 8'h00);
        wr(ADDR_PORT_A_DATA, 8'ha5);
        short_a <= 8'hff;
        wr(ADDR_DRIVE_LEVEL, 8'h00);
        repeat (4) @(negedge ref_clk);
        `CHK("pa_out", 8'ha5, pa_out)
        `CHK("pa_oe", 8'hff, pa_oe)
        `CHK("pull on output", 8'h00, pa_pull_en)
        rd(ADDR_PORT_A_DATA, v);
        `CHK("latch read", 8'ha5, v)
        short_a <= 8'h00;
        $display("done output");
    endtask

    task automatic t_input;
        logic [7:0] v;
        wr(ADDR_PORT_A_DIR, 8'hff);
        func_gpio_a <= 8'hfe;
        sw_a <= 8'h0f;
        repeat (5) @(negedge ref_clk);
        rd(ADDR_PORT_A_DATA, v);
        `CHK("pin read", 8'hf0, v)
        `CHK("pull gated", 8'hfe, pa_pull_en)
        wr(ADDR_PU_STRENGTH, 8'hff);
        rd(ADDR_PU_STRENGTH, v);
        `CHK("strength read", 8'h01, v)
        `CHK("strong a", 8'hfe, pa_pull_strong)
        wr(ADDR_PORT_A_PU, 8'h0f);
        repeat (2) @(negedge ref_clk);
        `CHK("strong off", 8'h0e, pa_pull_strong)
        func_gpio_a <= 8'hff;
        sw_a <= 8'h00;
        wr(ADDR_PORT_A_PU, 8'hff);
        $display("done input");
    endtask

    task automatic t_port_b;
        logic [7:0] v;
        wr(ADDR_PORT_B_DIR, 8'h1c);
        wr(ADDR_PORT_B_DATA, 8'hff);
        wr(ADDR_PORT_B_PU, 8'hff);
        repeat (4) @(negedge ref_clk);
        `CHK("pb_oe", 5'h03, pb_oe)
        `CHK("pb pull", 5'h1c, pb_pull_en)
        `CHK("pb strong", 5'h1c, pb_pull_strong)
        rd(ADDR_PORT_B_DATA, v);
        `CHK("pb data", 8'h1f, v)
        rd(ADDR_PORT_B_DIR, v);
        `CHK("pb dir", 8'h1c, v)
        rd(ADDR_PORT_B_PU, v);
        `CHK("pb pull reg", 8'h1f, v)
        $display("done port b");
    endtask

    task automatic t_drive;
        logic [7:0] v;
        logic [7:0] d;
        for (int k = 0; k < 4; k++)
        begin
            d = 8'h55 * k[7:0];
            wr(ADDR_DRIVE_LEVEL, d);
            rd(ADDR_DRIVE_LEVEL, v);
            `CHK("drive read", d, v)
            `CHK("drive pins", d, drive_level)
        end
        $display("done drive");
    endtask

    task automatic t_wake;
        int n;
        wr(ADDR_PORT_A_WAKE, 8'h08);
        @(posedge ref_clk);
        cpu_idle <= 1'b1;
        sw_a <= 8'h0c;
        count_wake(n);
        `CHK("wake pulses", 1, n)
        @(posedge ref_clk);
        sw_a <= 8'h00;
        cpu_idle <= 1'b0;
        repeat (4) @(posedge ref_clk);
        sw_a <= 8'h08;
        count_wake(n);
        `CHK("wake awake", 0, n)
        @(posedge ref_clk);
        sw_a <= 8'h00;
        cpu_idle <= 1'b1;
        wr(ADDR_PORT_A_DIR, 8'hf7);
        wr(ADDR_PORT_A_DATA, 8'hf7);
        count_wake(n);
        `CHK("wake output", 0, n)
        $display("done wake");
    endtask

    task automatic t_watchdog;
        logic [7:0] v;
        wr(ADDR_PORT_A_DIR, 8'h3c);
        @(posedge ref_clk);
        wdt_rst <= 1'b1;
        @(posedge ref_clk);
        wdt_rst <= 1'b0;
        cpu_idle <= 1'b0;
        rd(ADDR_PORT_A_DIR, v);
        `CHK("kept dir", 8'h3c, v)
        @(posedge ref_clk);
        wdt_rst <= 1'b1;
        @(posedge ref_clk);
        wdt_rst <= 1'b0;
        rd(ADDR_PORT_A_DIR, v);
        `CHK("restored dir", 8'hff, v)
        $display("done watchdog");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        mem_addr = 8'h00;
        mem_wdata = 8'h00;
        cpu_idle = 1'b0;
        wdt_rst = 1'b0;
        func_gpio_a = 8'hff;
        func_gpio_b = 5'h1f;
        sw_a = 8'h00;
        short_a = 8'h00;
        repeat (5) @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_output();
        t_input();
        t_port_b();
        t_drive();
        t_wake();
        t_watchdog();
        finish_test();
    end
endmodule
